// ==== tmo_oc_pwm.sv ====
// Output compare and PWM timer: counter, prescaler, six compare
// channels with pair linking, APB register slave.
// Assumes one clock pclk and an APB master in the same domain.
//
// Added by the designer: the address map and the APB interface to the registers.
`default_nettype none
`include "tmo_params.svh"

// Operation
// - On counter match, set, clear or toggle pin per compare action.
// - Compare match can raise a per-channel interrupt request when enabled.
// - Unbuffered value writes take effect at once, no shadow copy.
// - Value written below the counter yields no match that period.
// - Compare request at pulse end; overflow request at period end.
// - Even channel link bit pairs 0/1, 2/3, 4/5 onto even pin.
// - Even set drives first; odd write takes over at next overflow.
// - Each later overflow selects the most recently written set.
// - Even control register governs linked pair; odd one unused.
// - Linked odd channel releases its pin for general use.
// - Toggle-on-overflow toggles pin at modulo; modulo sets period.
// - Pulse width is overflow-to-match time, set by compare value.
// - Modulo 0x00FF, prescaler zero gives 256 clock period.
// - Value 0x0080 with 8-bit period gives half duty; linear scale.
// - Unsynchronised unbuffered writes may disturb two periods.
// - Mode 01 unbuffered, 10 buffered; edge bits 10 clear, 11 set.
// - Link bit has priority over the other mode select bit.
// - No overflow toggle gives 0% duty; max bit with toggle 100%.
// - Flag set on every compare; request gated by enable bit.
module tmo_oc_pwm #(
  parameter int NUM_CH = `TMO_NUM_CH,
  parameter int CNT_W = `TMO_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tmo_pkg::tmo_word_type pwdata,
  output tmo_pkg::tmo_word_type prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] chan_pin,
  output logic [NUM_CH-1:0] chan_pin_oe,
  output logic [NUM_CH-1:0] chan_irq,
  output logic ovf_irq
);
  import tmo_pkg::*;

  localparam int NPAIR = NUM_CH / 2;

  // -------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------
  // Channel decode: {hit, is_value, index}
  function automatic logic [4:0] decode_ch(input logic [7:0] a);
    logic [7:0] off;
    logic ok;
    off = a - `TMO_ADDR_CH_BASE;
    ok = (a >= `TMO_ADDR_CH_BASE) && (off[1:0] == 2'h0) &&
         (off[7:6] == 2'h0) && (int'(off[5:3]) < NUM_CH);
    decode_ch = {ok, off[2], off[5:3]};
  endfunction

  // Pin level after a compare action
  function automatic logic apply_act(input logic p, input logic [1:0] a);
    unique case (tmo_action_type'(a))
      TMO_ACT_TOGGLE: apply_act = ~p;
      TMO_ACT_CLEAR: apply_act = 1'b0;
      TMO_ACT_SET: apply_act = 1'b1;
      TMO_ACT_NONE: apply_act = p;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // Bus phase decode
  // -------------------------------------------------------------------
  logic setup, wr_acc;
  logic [4:0] dec_acc, dec_set;
  logic val_wr, ctrl_wr, tsc_wr, mod_wr;
  logic [NUM_CH-1:0][CNT_W-1:0] val_q;

  // Writes take effect only at the access edge
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign dec_acc = decode_ch(paddr);
  assign dec_set = dec_acc;
  assign val_wr = wr_acc & dec_acc[4] & dec_acc[3];
  assign ctrl_wr = wr_acc & dec_acc[4] & ~dec_acc[3];
  assign tsc_wr = wr_acc & (paddr == `TMO_ADDR_TSC);
  assign mod_wr = wr_acc & (paddr == `TMO_ADDR_MOD);

  // Value store: writes replace the compared word immediately
  tmo_chan_mem #(
    .NUM_CH(NUM_CH),
    .CNT_W(CNT_W)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(val_wr),
    .wr_idx(dec_acc[2:0]),
    .wr_data(pwdata[CNT_W-1:0]),
    .val_q(val_q)
  );

  // -------------------------------------------------------------------
  // Counter and prescaler
  // -------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q, cnt_d, mod_q, mod_d, cnt_nxt;
  logic [`TMO_DIV_W-1:0] div_q, div_d, div_mask;
  logic [2:0] ps_q, ps_d;
  logic stop_q, stop_d, oie_q, oie_d, ovf_q, ovf_d;
  logic tick, ovf_evt;

  // Tick when the low ps bits of the divider are all ones
  assign div_mask = ~(7'h7F << ps_q);
  assign tick = ~stop_q & ((div_q & div_mask) == div_mask);
  assign ovf_evt = tick & (cnt_q == mod_q);
  assign cnt_nxt = ovf_evt ? '0 : cnt_q + 1'b1;

  // Next counter and timer control state
  always_comb begin
    cnt_d = cnt_q;
    div_d = div_q;
    mod_d = mod_q;
    ps_d = ps_q;
    stop_d = stop_q;
    oie_d = oie_q;
    ovf_d = ovf_q;
    if (!stop_q) begin
      div_d = div_q + 1'b1;
    end
    if (tick) begin
      cnt_d = cnt_nxt;
    end
    if (mod_wr) begin
      mod_d = pwdata[CNT_W-1:0];
    end
    if (tsc_wr) begin
      ps_d = pwdata[`TMO_TSC_PS_HI:0];
      stop_d = pwdata[`TMO_TSC_STOP];
      oie_d = pwdata[`TMO_TSC_OIE];
      if (pwdata[`TMO_TSC_OVF]) begin
        ovf_d = 1'b0;
      end
      // Counter reset also restarts the prescaler phase
      if (pwdata[`TMO_TSC_RST]) begin
        cnt_d = '0;
        div_d = '0;
      end
    end
    // Overflow set wins over a clear in the same cycle
    if (ovf_evt) begin
      ovf_d = 1'b1;
    end
  end

  // Counter registers; stopped after reset until software starts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      div_q <= '0;
      mod_q <= `TMO_MOD_RESET;
      ps_q <= 3'h0;
      stop_q <= `TMO_STOP_RESET;
      oie_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
      mod_q <= mod_d;
      ps_q <= ps_d;
      stop_q <= stop_d;
      oie_q <= oie_d;
      ovf_q <= ovf_d;
    end
  end

  // -------------------------------------------------------------------
  // Channels
  // -------------------------------------------------------------------
  tmo_ctrl_type [NUM_CH-1:0] ctrl_q, ctrl_d;
  logic [NUM_CH-1:0] pin_q, pin_d, oe_c;
  logic [NPAIR-1:0] sel_q, sel_d, last_q, last_d;

  // Compare, pin and flag update for every channel
  always_comb begin
    int p;
    logic even, link, owned, oc, match;
    logic [CNT_W-1:0] act_val;
    tmo_ctrl_type c, w;
    p = 0;
    even = 1'b0;
    link = 1'b0;
    owned = 1'b0;
    oc = 1'b0;
    match = 1'b0;
    act_val = '0;
    c = '0;
    w = tmo_ctrl_type'(pwdata[7:0]);
    ctrl_d = ctrl_q;
    pin_d = pin_q;
    sel_d = sel_q;
    last_d = last_q;
    oe_c = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      p = i / 2;
      even = (i % 2) == 0;
      c = ctrl_q[i];
      link = ctrl_q[2 * p].mode_select_high;
      // Linked even pin uses the selected register set
      act_val = (even && link && sel_q[p]) ? val_q[i | 1] : val_q[i];
      owned = even || !link;
      oc = owned && (c.mode_select_high || c.mode_select_low);
      // Match when the counter enters the value, so an earlier value
      // written after the counter passed it waits for the next period
      match = tick && oc && (cnt_nxt == act_val);
      oe_c[i] = oc && ({c.edge_level_select_high,
                        c.edge_level_select_low} != 2'h0);
      if (oc) begin
        if (ovf_evt && c.toggle_on_overflow) begin
          pin_d[i] = ~pin_q[i];
        end
        if (match) begin
          pin_d[i] = apply_act(pin_d[i], {c.edge_level_select_high,
                                          c.edge_level_select_low});
        end
        // Full duty holds the pulse level; no toggle keeps it still
        if (c.max_duty_bit && c.toggle_on_overflow) begin
          pin_d[i] = ~c.edge_level_select_low;
        end
      end
      if (ctrl_wr && (int'(dec_acc[2:0]) == i)) begin
        ctrl_d[i].channel_irq_enable = w.channel_irq_enable;
        ctrl_d[i].mode_select_high = even ? w.mode_select_high : 1'b0;
        ctrl_d[i].mode_select_low = w.mode_select_low;
        ctrl_d[i].edge_level_select_high = w.edge_level_select_high;
        ctrl_d[i].edge_level_select_low = w.edge_level_select_low;
        ctrl_d[i].toggle_on_overflow = w.toggle_on_overflow;
        ctrl_d[i].max_duty_bit = w.max_duty_bit;
        if (w.channel_event_flag) begin
          ctrl_d[i].channel_event_flag = 1'b0;
        end
        // A fresh link starts on the even set
        if (even && w.mode_select_high && !c.mode_select_high) begin
          sel_d[p] = 1'b0;
          last_d[p] = 1'b0;
        end
      end
      // Hardware set wins over a software clear
      if (match) begin
        ctrl_d[i].channel_event_flag = 1'b1;
      end
    end
    for (int k = 0; k < NPAIR; k++) begin
      if (val_wr && (int'(dec_acc[2:1]) == k)) begin
        last_d[k] = dec_acc[0];
      end
      if (!ctrl_q[2 * k].mode_select_high) begin
        sel_d[k] = 1'b0;
      end else if (ovf_evt) begin
        sel_d[k] = last_d[k];
      end
    end
  end

  // Channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      pin_q <= '0;
      sel_q <= '0;
      last_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      pin_q <= pin_d;
      sel_q <= sel_d;
      last_q <= last_d;
    end
  end

  // Requests are flag and enable; odd flags never set while linked
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chan_irq[i] = ctrl_q[i].channel_event_flag &
                    ctrl_q[i].channel_irq_enable;
    end
  end
  assign ovf_irq = ovf_q & oie_q;
  assign chan_pin = pin_q;
  assign chan_pin_oe = oe_c;

  // -------------------------------------------------------------------
  // APB read path
  // -------------------------------------------------------------------
  tmo_word_type rd_q, rd_d;
  logic hit_q, hit_d;

  // Read data and address check are latched in the setup cycle, so
  // the access phase never waits
  always_comb begin
    rd_d = rd_q;
    hit_d = hit_q;
    if (setup) begin
      rd_d = '0;
      hit_d = 1'b1;
      if (paddr == `TMO_ADDR_TSC) begin
        rd_d[`TMO_TSC_OVF] = ovf_q;
        rd_d[`TMO_TSC_OIE] = oie_q;
        rd_d[`TMO_TSC_STOP] = stop_q;
        rd_d[`TMO_TSC_PS_HI:0] = ps_q;
      end else if (paddr == `TMO_ADDR_CNT) begin
        rd_d[CNT_W-1:0] = cnt_q;
      end else if (paddr == `TMO_ADDR_MOD) begin
        rd_d[CNT_W-1:0] = mod_q;
      end else if (dec_set[4] && dec_set[3]) begin
        rd_d[CNT_W-1:0] = val_q[dec_set[2:0]];
      end else if (dec_set[4]) begin
        rd_d[7:0] = ctrl_q[dec_set[2:0]];
      end else begin
        hit_d = 1'b0;
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
      hit_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      hit_q <= hit_d;
    end
  end

  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_q;

endmodule

`default_nettype wire

// ==== tmo_params.svh ====
// Constants of the output compare / PWM timer: offsets, resets, codes.
// Assumes byte addresses on an APB bus with 32-bit data words.
`ifndef TMO_PARAMS_SVH
`define TMO_PARAMS_SVH

// ---------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------
`define TMO_NUM_CH 6
`define TMO_CNT_W 16
`define TMO_DIV_W 7

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define TMO_ADDR_TSC 8'h00
`define TMO_ADDR_CNT 8'h04
`define TMO_ADDR_MOD 8'h08
`define TMO_ADDR_CH_BASE 8'h0C

// ---------------------------------------------------------------------
// Timer status/control bit positions
// ---------------------------------------------------------------------
`define TMO_TSC_OVF 7
`define TMO_TSC_OIE 6
`define TMO_TSC_STOP 5
`define TMO_TSC_RST 4
`define TMO_TSC_PS_HI 2

// ---------------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------------
`define TMO_MOD_RESET 16'hFFFF
`define TMO_STOP_RESET 1'h1
`define TMO_VAL_RESET 16'h0000

`endif

// ==== tmo_pkg.sv ====
// Types shared by the output compare / PWM timer files.
// Assumes nothing beyond the constants header.
`default_nettype none

package tmo_pkg;

  // -------------------------------------------------------------------
  // Bus word and channel control layout
  // -------------------------------------------------------------------
  typedef logic [31:0] tmo_word_type;

  // Channel control/status byte, bit 7 down to bit 0
  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic mode_select_high;
    logic mode_select_low;
    logic edge_level_select_high;
    logic edge_level_select_low;
    logic toggle_on_overflow;
    logic max_duty_bit;
  } tmo_ctrl_type;

  // Compare action selected by the edge/level bits
  typedef enum logic [1:0] {
    TMO_ACT_NONE = 2'h0,
    TMO_ACT_TOGGLE = 2'h1,
    TMO_ACT_CLEAR = 2'h2,
    TMO_ACT_SET = 2'h3
  } tmo_action_type;

endpackage

`default_nettype wire

// ==== tmo_chan_mem.sv ====
// Store of the channel compare values, one word per channel.
// Assumes one write request per cycle from the bus slave.
`default_nettype none
`include "tmo_params.svh"

module tmo_chan_mem #(
  parameter int NUM_CH = `TMO_NUM_CH,
  parameter int CNT_W = `TMO_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [CNT_W-1:0] wr_data,
  output logic [NUM_CH-1:0][CNT_W-1:0] val_q
);
  import tmo_pkg::*;

  logic [NUM_CH-1:0][CNT_W-1:0] val_d;

  // Next values: only the addressed word changes
  always_comb begin
    val_d = val_q;
    if (wr_en && (int'(wr_idx) < NUM_CH)) begin
      val_d[wr_idx] = wr_data;
    end
  end

  // All words are registers so the comparators see them in parallel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= '0;
    end else begin
      val_q <= val_d;
    end
  end

endmodule

`default_nettype wire

// ==== tmo_oc_pwm_properties.sv ====
// Port assertions for the output compare / PWM timer.
// Assumes the APB map of the timer: last mapped word at 8'h38.
`default_nettype none

module tmo_oc_pwm_chk #(
  parameter int NUM_CH = 6,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tmo_pkg::tmo_word_type prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] chan_pin,
  input wire logic [NUM_CH-1:0] chan_irq,
  input wire logic ovf_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmo_pkg::*;
  logic acc;
  logic unmapped;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Bus and request relations
  // ----------------------------------------------------------------
  // Access phase and address decode seen from the bus side
  assign acc = psel && penable;
  assign unmapped = paddr > 8'h38;

  chk_ready_always:
    assert property (pready) else $error("pready low");
  chk_err_unmapped:
    assert property (acc && unmapped |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped:
    assert property (acc && !unmapped && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  chk_err_access_only:
    assert property (pslverr |-> acc) else $error("error outside access");
  chk_unmapped_zero:
    assert property (acc && !pwrite && unmapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero:
    assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_ovf_clear_cause:
    assert property ($fell(ovf_irq) |->
      $past(acc && pwrite && paddr == 8'h00))
    else $error("overflow request fell without timer write");
  chk_chan_clear_cause:
    assert property (|($past(chan_irq) & ~chan_irq) |-> $past(acc && pwrite))
    else $error("channel request fell without write");
  chk_reset_quiet:
    assert property ($rose(presetn) |->
      chan_pin == '0 && chan_irq == '0 && !ovf_irq)
    else $error("outputs active after reset");
endmodule

bind tmo_oc_pwm tmo_oc_pwm_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .chan_pin(chan_pin),
  .chan_irq(chan_irq),
  .ovf_irq(ovf_irq)
);

`default_nettype wire

// ==== tmo_pin_probe.sv ====
// Load on the channel pins: measures high time and period of one pin.
// Assumes a pull-down on every pin, so a released pin reads low.
`default_nettype none

module tmo_pin_probe (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] chan_pin,
  input wire logic [5:0] chan_pin_oe,
  input wire logic [2:0] sel,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rise_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  logic lvl_q;
  logic [15:0] run_q;

  // Undriven pin falls to the pull-down level
  assign lvl = chan_pin_oe[sel] ? chan_pin[sel] : 1'b0;

  // Run length counted from each rising edge of the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
      run_q <= 16'h0;
      hi_len <= 16'h0;
      per_len <= 16'h0;
      rise_cnt <= 16'h0;
    end else begin
      lvl_q <= lvl;
      run_q <= run_q + 16'h1;
      if (lvl && !lvl_q) begin
        per_len <= run_q;
        run_q <= 16'h1;
        rise_cnt <= rise_cnt + 16'h1;
      end
      if (!lvl && lvl_q) begin
        hi_len <= run_q;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tmo_oc_pwm_tb.sv ====
// Self-checking bench for the output compare / PWM timer.
// Assumes the pin probe model and the bound port checker.
`default_nettype none

module tmo_oc_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf_irq;
  logic [7:0] paddr;
  tmo_word_type pwdata, prdata, rd;
  logic [5:0] chan_pin, chan_pin_oe, chan_irq;
  logic [2:0] probe_sel;
  logic [15:0] hi_len, per_len, rise_cnt;
  logic err;
  int failures = 0;
  int check_count = 0;

  tmo_oc_pwm dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_pin(chan_pin), .chan_pin_oe(chan_pin_oe),
    .chan_irq(chan_irq), .ovf_irq(ovf_irq));
  tmo_pin_probe load (.pclk(pclk), .presetn(presetn), .chan_pin(chan_pin),
    .chan_pin_oe(chan_pin_oe), .sel(probe_sel), .hi_len(hi_len),
    .per_len(per_len), .rise_cnt(rise_cnt));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timed_out(input string what);
    failures++;
    $display("[ERR] %s expected event seen timeout", what);
    complete_run();
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w,
                      input tmo_word_type wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timed_out("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  // Index 6 waits for the overflow request
  task automatic wait_irq(input int idx);
    int n;
    n = 0;
    while ((idx == 6 ? ovf_irq : chan_irq[idx]) !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) timed_out("request");
  endtask

  // Two fresh rising edges give one whole period of the pin
  task automatic measure(input logic [2:0] ch, input logic [15:0] hi,
                         input logic [15:0] per);
    int n;
    logic [15:0] r;
    probe_sel <= ch;
    @(posedge pclk);
    r = rise_cnt;
    n = 0;
    while (16'(rise_cnt - r) < 16'h2 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) timed_out("pin edge");
    chk("high time", 32'(hi), 32'(hi_len));
    chk("period", 32'(per), 32'(per_len));
  endtask

  // Settle one period, then count high samples over 300 cycles
  task automatic count_high(input int ch, input logic [31:0] exp);
    logic [31:0] h;
    repeat (300) @(posedge pclk);
    h = 32'h0;
    repeat (300) begin
      @(posedge pclk);
      h = h + 32'(chan_pin[ch]);
    end
    chk("high samples", exp, h);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk("timer ctrl", 8'h00, 32'h20);
    rd_chk("modulo", 8'h08, 32'hFFFF);
    rd_chk("counter", 8'h04, 32'h0);
    rd_chk("ch0 ctrl", 8'h0C, 32'h0);
    rd_chk("ch5 value", 8'h38, 32'h0);
    rd_chk("unmapped data", 8'h40, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    xfer(8'h14, 1'b1, 32'h20);
    rd_chk("odd link bit", 8'h14, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic t_pwm_basic();
    xfer(8'h00, 1'b1, 32'h30);
    xfer(8'h08, 1'b1, 32'hFF);
    xfer(8'h10, 1'b1, 32'h80);
    xfer(8'h0C, 1'b1, 32'h1A);
    xfer(8'h00, 1'b1, 32'h00);
    measure(0, 16'h80, 16'h100);
    chk("ch0 driven", 32'h1, 32'(chan_pin_oe[0]));
    $display("test pwm_basic done");
  endtask

  task automatic t_irq_sync();
    xfer(8'h0C, 1'b1, 32'hDA);
    wait_irq(0);
    chk("pin at compare request", 32'h0, 32'(chan_pin[0]));
    xfer(8'h10, 1'b1, 32'h40);
    xfer(8'h0C, 1'b1, 32'hDA);
    xfer(8'h00, 1'b1, 32'hC0);
    wait_irq(6);
    chk("pin at overflow request", 32'h1, 32'(chan_pin[0]));
    chk("no match below counter", 32'h0, 32'(chan_irq[0]));
    xfer(8'h10, 1'b1, 32'h90);
    measure(0, 16'h90, 16'h100);
    xfer(8'h0C, 1'b1, 32'h9A);
    xfer(8'h00, 1'b1, 32'h80);
    @(posedge pclk);
    chk("channel request off", 32'h0, 32'(chan_irq[0]));
    chk("overflow request off", 32'h0, 32'(ovf_irq));
    $display("test irq_sync done");
  endtask

  task automatic t_duty_ends();
    xfer(8'h0C, 1'b1, 32'h18);
    count_high(0, 32'd0);
    xfer(8'h0C, 1'b1, 32'h1B);
    count_high(0, 32'd300);
    $display("test duty_ends done");
  endtask

  task automatic t_buffered();
    xfer(8'h20, 1'b1, 32'h40);
    xfer(8'h1C, 1'b1, 32'h3A);
    xfer(8'h24, 1'b1, 32'h18);
    measure(2, 16'h40, 16'h100);
    chk("odd pin released", 32'h0, 32'(chan_pin_oe[3]));
    xfer(8'h28, 1'b1, 32'hC0);
    measure(2, 16'hC0, 16'h100);
    xfer(8'h20, 1'b1, 32'h20);
    measure(2, 16'h20, 16'h100);
    rd_chk("odd ctrl unused", 8'h24, 32'h18);
    xfer(8'h1C, 1'b0, 32'h0);
    chk("even flag reports", 32'h1, 32'(rd[7]));
    $display("test buffered done");
  endtask

  // Toggle on compare alone: one pin edge per counter period
  task automatic t_toggle_cmp();
    xfer(8'h30, 1'b1, 32'h10);
    xfer(8'h2C, 1'b1, 32'h14);
    measure(4, 16'h100, 16'h200);
    $display("test toggle_cmp done");
  endtask

  // Reset, then the scenarios in order
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    probe_sel = 3'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_pwm_basic();
    t_irq_sync();
    t_duty_ends();
    t_buffered();
    t_toggle_cmp();
    complete_run();
  end
endmodule

`default_nettype wire
